// ==== design/flash_guard_pkg.sv ====
// Constants, types and carriers shared by the flash guard block.
package flash_guard_pkg;

	// Operation codes, shifted most significant bit first.
	localparam logic [7:0] OP_RD_STAT    = 8'h05;
	localparam logic [7:0] OP_WR_EN      = 8'h06;
	localparam logic [7:0] OP_WR_DIS     = 8'h04;
	localparam logic [7:0] OP_WR_STAT    = 8'h01;
	localparam logic [7:0] OP_PROG       = 8'h02;
	localparam logic [7:0] OP_PROG_DUAL  = 8'hD2;
	localparam logic [7:0] OP_PROG_QUAD  = 8'h12;
	localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
	localparam logic [7:0] OP_ERASE_SECT = 8'hD8;
	localparam logic [7:0] OP_WR_SETUP   = 8'hB1;

	// Status register bit positions.
	localparam int SB_BUSY      = 0;
	localparam int SB_WEL       = 1;
	localparam int SB_GUARD_B0  = 2;
	localparam int SB_GUARD_LOW = 5;
	localparam int SB_GUARD_B3  = 6;
	localparam logic [7:0] STAT_WR_MASK = 8'h7C;
	localparam logic [7:0] STAT_RESET   = 8'h00;

	// Boot setup word layout: 1111 111y xxxx 1111.
	localparam int SETUP_AW_BIT    = 8;
	localparam int SETUP_DUMMY_LSB = 4;
	localparam logic [15:0] SETUP_FIXED_MASK = 16'hFE0F;
	localparam logic [15:0] SETUP_FIXED_VAL  = 16'hFE0F;
	localparam logic [15:0] SETUP_RESET      = 16'hFFFF;
	localparam logic [3:0]  DUMMY_DEF_X1     = 4'h8;
	localparam logic [3:0]  DUMMY_DEF_X4     = 4'hA;

	// Array geometry of the 32-sector part.
	localparam int SECT_LSB = 16;
	localparam int SECT_W   = 5;

	// Busy times of the array cycles.
	localparam int CLK_PERIOD_NS   = 40;
	localparam int PROG_TIME_NS    = 2000;
	localparam int SECT_TIME_NS    = 40000;
	localparam int BULK_TIME_NS    = 80000;
	localparam int STAT_TIME_NS    = 4000;
	localparam int SETUP_TIME_NS   = 4000;
	localparam logic [11:0] PROG_CYC  = 12'(PROG_TIME_NS / CLK_PERIOD_NS);
	localparam logic [11:0] SECT_CYC  = 12'(SECT_TIME_NS / CLK_PERIOD_NS);
	localparam logic [11:0] BULK_CYC  = 12'(BULK_TIME_NS / CLK_PERIOD_NS);
	localparam logic [11:0] STAT_CYC  = 12'(STAT_TIME_NS / CLK_PERIOD_NS);
	localparam logic [11:0] SETUP_CYC = 12'(SETUP_TIME_NS / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		K_NONE       = 3'h0,
		K_PROG       = 3'h1,
		K_ERASE_SECT = 3'h2,
		K_ERASE_BULK = 3'h3,
		K_WR_STAT    = 3'h4,
		K_WR_SETUP   = 3'h5
	} op_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} cycle_state_t;

	typedef struct packed {
		logic        start;
		op_kind_t    kind;
		logic [31:0] addr;
	} array_op_t;

endpackage : flash_guard_pkg

// ==== design/flash_guard.sv ====
// Status, write latch, block guard and boot setup logic of a serial flash.
`timescale 1ns/100ps

// Function
// - Setup word keeps its fixed one bits.
// - Width bit clear means four-byte addressing.
// - Dummy field one to fourteen is count.
// - Dummy field zero or all ones: default.
// - Write disable clears the write latch.
// - Latch clears at reset and at the end of every cycle except a setup write.
// - Read status shifts out the status.
// - Busy bit high while array cycle runs.
// - Latch clear refuses program and erase.
// - Guard-low bit picks top or bottom.
// - Guard bits stored, define protected region.
// - Bulk erase only with guard bits zero.
// - Guarded sectors refuse program and erase.
// - Codes guard 1,2,4,8,16 or all sectors.
// - Write enable sets the write latch.
// - Non byte-aligned write frames are rejected, except write enable and write disable.
// - Bits shift most significant first.
// - Busy device ignores all access but status.
module flash_guard (
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	input  wire logic                       serial_clock_in,
	input  wire logic                       cs_n,
	input  wire logic                       data_in,
	output logic                            data_out,
	output logic                            data_oe,
	input  wire logic                       four_lane_boot,
	output logic [7:0]                      flash_state_and_guard,
	output logic                            addr_four_byte_q,
	output logic [3:0]                      dummy_clocks_q,
	output flash_guard_pkg::array_op_t      array_op_q
);
	import flash_guard_pkg::*;

	// Link side: runs on serial_clock_in, which only toggles inside a frame.
	logic       armed_q;
	logic [2:0] bit_cnt_q;
	logic [2:0] bit_cnt_n;
	logic [6:0] shift_q;
	logic [7:0] link_byte_q;
	logic       byte_tgl_q;
	logic       first_q;
	logic       rd_mode_q;
	logic [7:0] stat_l1_q;
	logic [7:0] stat_l2_q;
	logic [7:0] snap_q;
	logic       byte_done;

	assign bit_cnt_n = armed_q ? 3'h0 : bit_cnt_q;
	assign byte_done = (bit_cnt_n == 3'h7);

	// Deselect presets the frame marker; the first edge of a frame consumes it.
	always_ff @(posedge serial_clock_in or posedge cs_n) begin
		if (cs_n) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= 1'b0;
		end
	end

	// The bit count survives deselect so the system side can judge alignment.
	always_ff @(posedge serial_clock_in or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_q   <= 3'h0;
			shift_q     <= 7'h00;
			link_byte_q <= 8'h00;
			byte_tgl_q  <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_n + 3'h1;
			shift_q   <= {shift_q[5:0], data_in};
			if (byte_done) begin
				link_byte_q <= {shift_q, data_in};
				byte_tgl_q  <= ~byte_tgl_q;
			end
		end
	end

	always_ff @(posedge serial_clock_in or negedge rstn) begin
		if (!rstn) begin
			first_q   <= 1'b0;
			rd_mode_q <= 1'b0;
		end else begin
			if (armed_q) begin
				first_q   <= 1'b1;
				rd_mode_q <= 1'b0;
			end
			if (byte_done) begin
				first_q <= 1'b0;
				if ((armed_q || first_q) && {shift_q, data_in} == OP_RD_STAT) begin
					rd_mode_q <= 1'b1;
				end
			end
		end
	end

	// Status crosses as a slow word; a snapshot per byte keeps each byte whole.
	always_ff @(posedge serial_clock_in or negedge rstn) begin
		if (!rstn) begin
			stat_l1_q <= STAT_RESET;
			stat_l2_q <= STAT_RESET;
			snap_q    <= STAT_RESET;
		end else begin
			stat_l1_q <= flash_state_and_guard;
			stat_l2_q <= stat_l1_q;
			if (byte_done) begin
				snap_q <= stat_l2_q;
			end
		end
	end

	// Output changes on the falling edge; status repeats until deselect.
	always_ff @(negedge serial_clock_in or posedge cs_n) begin
		if (cs_n) begin
			data_oe  <= 1'b0;
			data_out <= 1'b0;
		end else begin
			data_oe  <= rd_mode_q;
			data_out <= snap_q[3'h7 - bit_cnt_q];
		end
	end

	// System side.
	logic         cs_s1_q, cs_s2_q, cs_s3_q, cs_s4_q;
	logic         tg_s1_q, tg_s2_q, tg_s3_q;
	logic [2:0]   bc_s1_q, bc_s2_q;
	logic         lane_s1_q, lane_s2_q;
	logic         frame_start, frame_end, byte_evt;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			cs_s3_q   <= 1'b1;
			cs_s4_q   <= 1'b1;
			tg_s1_q   <= 1'b0;
			tg_s2_q   <= 1'b0;
			tg_s3_q   <= 1'b0;
			bc_s1_q   <= 3'h0;
			bc_s2_q   <= 3'h0;
			lane_s1_q <= 1'b0;
			lane_s2_q <= 1'b0;
		end else begin
			cs_s1_q   <= cs_n;
			cs_s2_q   <= cs_s1_q;
			cs_s3_q   <= cs_s2_q;
			cs_s4_q   <= cs_s3_q;
			tg_s1_q   <= byte_tgl_q;
			tg_s2_q   <= tg_s1_q;
			tg_s3_q   <= tg_s2_q;
			bc_s1_q   <= bit_cnt_q;
			bc_s2_q   <= bc_s1_q;
			lane_s1_q <= four_lane_boot;
			lane_s2_q <= lane_s1_q;
		end
	end

	// The end of frame is seen at least one cycle after the last byte event.
	assign frame_start = cs_s3_q && !cs_s2_q;
	assign frame_end   = cs_s3_q && !cs_s4_q;
	assign byte_evt    = tg_s2_q ^ tg_s3_q;

	// Frame decoding of opcode, address and data bytes.
	logic [7:0]  op_q;
	logic [3:0]  byte_idx_q;
	logic [2:0]  addr_cnt_q;
	logic [1:0]  data_cnt_q;
	logic [31:0] addr_q;
	logic [15:0] data_q;
	logic        has_addr;
	logic [2:0]  addr_len;

	assign has_addr = (op_q == OP_PROG) || (op_q == OP_PROG_DUAL) ||
	                  (op_q == OP_PROG_QUAD) || (op_q == OP_ERASE_SECT);
	assign addr_len = addr_four_byte_q ? 3'h4 : 3'h3;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			op_q       <= 8'h00;
			byte_idx_q <= 4'h0;
			addr_cnt_q <= 3'h0;
			data_cnt_q <= 2'h0;
			addr_q     <= 32'h0000_0000;
			data_q     <= 16'h0000;
		end else if (frame_start) begin
			byte_idx_q <= 4'h0;
			addr_cnt_q <= 3'h0;
			data_cnt_q <= 2'h0;
			addr_q     <= 32'h0000_0000;
		end else if (byte_evt) begin
			if (byte_idx_q != 4'hF) begin
				byte_idx_q <= byte_idx_q + 4'h1;
			end
			if (byte_idx_q == 4'h0) begin
				op_q <= link_byte_q;
			end else if (has_addr && addr_cnt_q != addr_len) begin
				addr_q     <= {addr_q[23:0], link_byte_q};
				addr_cnt_q <= addr_cnt_q + 3'h1;
			end else begin
				data_q <= {data_q[7:0], link_byte_q};
				if (data_cnt_q != 2'h3) begin
					data_cnt_q <= data_cnt_q + 2'h1;
				end
			end
		end
	end

	// Protection map of the 32-sector part.
	logic [2:0]        guard_code;
	logic [SECT_W:0]   guard_size;
	logic [SECT_W-1:0] sector;
	logic              sect_guarded;
	logic              any_guard;

	assign guard_code = flash_state_and_guard[SB_GUARD_B0 +: 3];
	assign any_guard  = |flash_state_and_guard[SB_GUARD_B0 +: 3] ||
	                    flash_state_and_guard[SB_GUARD_B3];
	assign sector     = addr_q[SECT_LSB +: SECT_W];

	always_comb begin
		guard_size   = 6'h00;
		sect_guarded = 1'b0;
		if (guard_code >= 3'h6 || flash_state_and_guard[SB_GUARD_B3]) begin
			sect_guarded = 1'b1;
		end else if (guard_code != 3'h0) begin
			guard_size = 6'h01 << (guard_code - 3'h1);
			if (flash_state_and_guard[SB_GUARD_LOW]) begin
				sect_guarded = ({1'b0, sector} < guard_size);
			end else begin
				sect_guarded = ({1'b0, sector} >= 6'h20 - guard_size);
			end
		end
	end

	// Frame-end evaluation; only a whole-byte frame may start a cycle.
	cycle_state_t state_q;
	logic         aligned;
	logic         go;
	op_kind_t     go_kind;
	logic         set_wel, clr_wel;

	assign aligned = (bc_s2_q == 3'h0) && (byte_idx_q != 4'h0);

	always_comb begin
		go      = 1'b0;
		go_kind = K_NONE;
		set_wel = 1'b0;
		clr_wel = 1'b0;
		if (frame_end && state_q == ST_IDLE && byte_idx_q != 4'h0) begin
			case (op_q)
				OP_WR_EN: begin
					set_wel = 1'b1;
				end
				OP_WR_DIS: begin
					clr_wel = 1'b1;
				end
				OP_PROG, OP_PROG_DUAL, OP_PROG_QUAD: begin
					go_kind = K_PROG;
					go = (addr_cnt_q == addr_len) && (data_cnt_q != 2'h0) &&
					     !sect_guarded;
				end
				OP_ERASE_SECT: begin
					go_kind = K_ERASE_SECT;
					go = (addr_cnt_q == addr_len) && !sect_guarded;
				end
				OP_ERASE_BULK: begin
					go_kind = K_ERASE_BULK;
					go = !any_guard;
				end
				OP_WR_STAT: begin
					go_kind = K_WR_STAT;
					go = (data_cnt_q != 2'h0);
				end
				OP_WR_SETUP: begin
					go_kind = K_WR_SETUP;
					go = (data_cnt_q == 2'h2) &&
					     ((data_q & SETUP_FIXED_MASK) == SETUP_FIXED_VAL);
				end
				default: begin
					go_kind = K_NONE;
				end
			endcase
			go = go && aligned && flash_state_and_guard[SB_WEL];
		end
	end

	// Array cycle timer.
	logic [11:0] busy_cnt_q;
	op_kind_t    kind_q;
	logic [15:0] pend_q;
	logic        done;

	assign done = (state_q == ST_BUSY) && (busy_cnt_q == 12'h001);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ST_IDLE;
			busy_cnt_q <= 12'h000;
			kind_q     <= K_NONE;
			pend_q     <= SETUP_RESET;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (go) begin
						state_q <= ST_BUSY;
						kind_q  <= go_kind;
						pend_q  <= data_q;
						case (go_kind)
							K_PROG:       busy_cnt_q <= PROG_CYC;
							K_ERASE_SECT: busy_cnt_q <= SECT_CYC;
							K_ERASE_BULK: busy_cnt_q <= BULK_CYC;
							K_WR_STAT:    busy_cnt_q <= STAT_CYC;
							default:      busy_cnt_q <= SETUP_CYC;
						endcase
					end
				end
				ST_BUSY: begin
					busy_cnt_q <= busy_cnt_q - 12'h001;
					if (done) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Status register; guard bits persist and change only by a status write.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flash_state_and_guard <= STAT_RESET;
		end else begin
			if (go) begin
				flash_state_and_guard[SB_BUSY] <= 1'b1;
			end else if (done) begin
				flash_state_and_guard[SB_BUSY] <= 1'b0;
			end
			if (set_wel) begin
				flash_state_and_guard[SB_WEL] <= 1'b1;
			end else if (clr_wel || (done && kind_q != K_WR_SETUP)) begin
				flash_state_and_guard[SB_WEL] <= 1'b0;
			end
			if (done && kind_q == K_WR_STAT) begin
				flash_state_and_guard[6:2] <= pend_q[6:2] & STAT_WR_MASK[6:2];
			end
		end
	end

	// Boot setup word; a broken write leaves the previous setting in place.
	logic [15:0] setup_q;
	logic [3:0]  dummy_field;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			setup_q <= SETUP_RESET;
		end else if (done && kind_q == K_WR_SETUP) begin
			setup_q <= pend_q;
		end
	end

	assign dummy_field = setup_q[SETUP_DUMMY_LSB +: 4];

	// Read timing outputs follow the stored word and the lane-mode pin.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			addr_four_byte_q <= 1'b0;
			dummy_clocks_q   <= DUMMY_DEF_X1;
		end else begin
			addr_four_byte_q <= !setup_q[SETUP_AW_BIT];
			if (dummy_field == 4'h0 || dummy_field == 4'hF) begin
				dummy_clocks_q <= lane_s2_q ? DUMMY_DEF_X4 : DUMMY_DEF_X1;
			end else begin
				dummy_clocks_q <= dummy_field;
			end
		end
	end

	// One-cycle start request to the array, only for accepted cycles.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			array_op_q <= '0;
		end else begin
			array_op_q.start <= go;
			array_op_q.kind  <= go ? go_kind : K_NONE;
			array_op_q.addr  <= addr_q;
		end
	end

endmodule : flash_guard

// ==== tb/flash_guard_monitor.sv ====
// Assertion checker for the flash guard top-level ports.
`timescale 1ns/100ps
module flash_guard_monitor (
	input wire logic                       clk_sys,
	input wire logic                       rstn,
	input wire logic                       cs_n,
	input wire logic                       data_oe,
	input wire logic [7:0]                 flash_state_and_guard,
	input wire logic [3:0]                 dummy_clocks_q,
	input wire flash_guard_pkg::array_op_t array_op_q
);
	import flash_guard_pkg::*;
	logic [5:0] limit;
	logic [2:0] code;
	op_kind_t   last_kind_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	assign code = flash_state_and_guard[4:2];
	// Sectors at or above this number are guarded when guarding from the top.
	assign limit = (flash_state_and_guard[SB_GUARD_B3] || code > 3'h5) ? 6'h00 :
		(code == 3'h0) ? 6'h20 : 6'h20 - (6'h01 << (code - 3'h1));
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			last_kind_q <= K_NONE;
		else if (array_op_q.start)
			last_kind_q <= array_op_q.kind;
	end
	chk_start_sets_busy: assert property (
		array_op_q.start |-> ##[0:2] flash_state_and_guard[SB_BUSY])
		else $error("accepted cycle without busy bit");
	chk_start_needs_latch: assert property (
		array_op_q.start |-> flash_state_and_guard[SB_WEL])
		else $error("cycle accepted with latch clear");
	chk_start_when_idle: assert property (
		array_op_q.start |-> !$past(flash_state_and_guard[SB_BUSY]) ##1 !array_op_q.start)
		else $error("cycle accepted while busy");
	chk_bulk_unguarded: assert property (
		array_op_q.start && array_op_q.kind == K_ERASE_BULK
		|-> flash_state_and_guard[6:2] == 5'h00 || flash_state_and_guard[6:2] == 5'h08)
		else $error("bulk erase with guard bits set");
	chk_guard_top_map: assert property (
		array_op_q.start && (array_op_q.kind == K_PROG || array_op_q.kind == K_ERASE_SECT)
		&& !flash_state_and_guard[SB_GUARD_LOW] |-> {1'b0, array_op_q.addr[20:16]} < limit)
		else $error("guarded sector accepted");
	chk_latch_end_clear: assert property (
		$fell(flash_state_and_guard[SB_BUSY]) && last_kind_q != K_WR_SETUP
		|-> !flash_state_and_guard[SB_WEL])
		else $error("latch kept after cycle end");
	chk_dummy_range: assert property (
		dummy_clocks_q != 4'h0 && dummy_clocks_q != 4'hF)
		else $error("dummy count out of range");
	chk_oe_in_frame: assert property (
		data_oe |-> !cs_n)
		else $error("data driven outside frame");
endmodule : flash_guard_monitor

bind flash_guard flash_guard_monitor flash_guard_monitor_inst (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.cs_n(cs_n),
	.data_oe(data_oe),
	.flash_state_and_guard(flash_state_and_guard),
	.dummy_clocks_q(dummy_clocks_q),
	.array_op_q(array_op_q)
);

// ==== tb/flash_host_model.sv ====
// Behavioural configuration host that frames serial transfers.
`timescale 1ns/100ps
module flash_host_model (
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      serial_clock_in,
	output logic      cs_n,
	output logic      data_in
);
	initial begin
		serial_clock_in = 1'b0;
		cs_n = 1'b1;
		data_in = 1'b0;
	end
	// The clock only runs inside frames, and chip select drops on whole bytes
	// unless the caller asks for a short frame on purpose.
	task automatic xfer(input logic [47:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		cs_n = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			data_in = tx[i];
			#24 serial_clock_in = 1'b1;
			// An undriven line reads as the inverse, so a missing enable shows as bad data.
			rx = {rx[6:0], data_oe ? data_out : ~data_out};
			#24 serial_clock_in = 1'b0;
		end
		#48 cs_n = 1'b1;
		data_in = ~data_in;
		#240;
	endtask : xfer
endmodule : flash_host_model

// ==== tb/flash_guard_tb_top.sv ====
// Self-checking bench for the flash guard block.
`timescale 1ns/100ps
module flash_guard_tb_top;
	import flash_guard_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic       four_lane_boot = 1'b0;
	logic       sclk;
	logic       cs_n;
	logic       data_in;
	logic       data_out;
	logic       data_oe;
	logic [7:0] flash_state_and_guard;
	logic       addr_four_byte_q;
	logic [3:0] dummy_clocks_q;
	array_op_t  array_op_q;
	array_op_t  exp_q[$];
	array_op_t  e;
	int         n_fail = 0;
	int         check_count = 0;
	logic [7:0] s;
	logic [7:0] g;
	logic [7:0] lfsr_q = 8'h2B;
	logic [3:0] d;
	int         n;

	always #20 clk_sys = ~clk_sys;

	flash_guard flash_guard_inst (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.serial_clock_in(sclk),
		.cs_n(cs_n),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe(data_oe),
		.four_lane_boot(four_lane_boot),
		.flash_state_and_guard(flash_state_and_guard),
		.addr_four_byte_q(addr_four_byte_q),
		.dummy_clocks_q(dummy_clocks_q),
		.array_op_q(array_op_q)
	);
	flash_host_model flash_host_model_inst (
		.data_out(data_out),
		.data_oe(data_oe),
		.serial_clock_in(sclk),
		.cs_n(cs_n),
		.data_in(data_in)
	);

	function automatic logic [7:0] lfsr_next(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic [47:0] tx, input int nb);
		logic [7:0] r;
		flash_host_model_inst.xfer(tx, nb, r);
	endtask : xfer

	task automatic rd(output logic [7:0] v);
		flash_host_model_inst.xfer({40'h0, OP_RD_STAT, 8'h00}, 16, v);
	endtask : rd

	task automatic push(input op_kind_t k, input logic [4:0] sect);
		exp_q.push_back('{start: 1'b1, kind: k, addr: {11'h000, sect, 16'h0000}});
	endtask : push

	// Busy is polled after each cycle-starting write; only the write disable after the sector erase lands mid-cycle.
	task automatic wait_idle;
		logic [7:0] v;
		for (int i = 0; i < 300; i++) begin
			rd(v);
			if (v[SB_BUSY] === 1'b0)
				return;
		end
		n_fail++;
		complete_run();
	endtask : wait_idle

	task automatic wr_stat(input logic [7:0] v);
		xfer(OP_WR_EN, 8);
		push(K_WR_STAT, 5'h00);
		xfer({OP_WR_STAT, v}, 16);
		wait_idle();
	endtask : wr_stat

	task automatic prog(input logic [4:0] sect, input bit ok);
		logic [7:0] v;
		lfsr_q = lfsr_next(lfsr_q);
		xfer(OP_WR_EN, 8);
		if (ok)
			push(K_PROG, sect);
		xfer({OP_PROG, 3'h0, sect, 16'h0000, lfsr_q}, 40);
		wait_idle();
		rd(v);
		check(v, ok ? g : g | 8'h02);
	endtask : prog

	// Sampled on the falling edge, well clear of the edge that launches the pulse.
	always @(negedge clk_sys) begin
		if (array_op_q.start === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
			check(array_op_q.kind, e.kind);
			if (e.kind == K_PROG || e.kind == K_ERASE_SECT)
				check(array_op_q.addr, e.addr);
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(dummy_clocks_q, DUMMY_DEF_X1);
		check(addr_four_byte_q, 1'b0);
		rd(s);
		check(s, STAT_RESET);
		xfer(OP_WR_EN, 8);
		rd(s);
		check(s, 8'h02);
		xfer(OP_WR_DIS, 8);
		rd(s);
		check(s, 8'h00);
		xfer({OP_ERASE_SECT, 24'h1F0000}, 32);
		rd(s);
		check(s, 8'h00);
		xfer(OP_WR_EN, 8);
		push(K_ERASE_SECT, 5'h1F);
		xfer({OP_ERASE_SECT, 24'h1F0000}, 32);
		rd(s);
		check(s, 8'h03);
		xfer(OP_WR_DIS, 8);
		rd(s);
		check(s, 8'h03);
		wait_idle();
		rd(s);
		check(s, 8'h00);
		xfer(OP_WR_EN, 8);
		xfer({OP_PROG, 24'h000000, 8'hA5, 8'h00} >> 1, 47);
		rd(s);
		check(s, 8'h02);
		for (int c = 0; c < 8; c++) begin
			g = {3'b000, 3'(c), 2'b00};
			wr_stat(g);
			rd(s);
			check(s, g);
			n = (c == 0) ? 0 : (c > 5) ? 32 : 1 << (c - 1);
			if (c != 0)
				prog(5'(32 - n), 1'b0);
			if (c < 6)
				prog(5'(31 - n), 1'b1);
		end
		g = 8'h24;
		wr_stat(g);
		prog(5'h00, 1'b0);
		prog(5'h1F, 1'b1);
		g = 8'h04;
		wr_stat(g);
		xfer(OP_WR_EN, 8);
		xfer(OP_ERASE_BULK, 8);
		rd(s);
		check(s, 8'h06);
		wr_stat(8'h00);
		xfer(OP_WR_EN, 8);
		push(K_ERASE_BULK, 5'h00);
		xfer(OP_ERASE_BULK, 8);
		wait_idle();
		rd(s);
		check(s, 8'h00);
		@(posedge clk_sys);
		four_lane_boot <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(dummy_clocks_q, DUMMY_DEF_X4);
		lfsr_q = lfsr_next(lfsr_q);
		d = 4'(1 + lfsr_q % 14);
		xfer(OP_WR_EN, 8);
		push(K_WR_SETUP, 5'h00);
		xfer({OP_WR_SETUP, 8'hFE, d, 4'hF}, 24);
		wait_idle();
		check(addr_four_byte_q, 1'b1);
		check(dummy_clocks_q, d);
		xfer({OP_WR_SETUP, 8'h7E, d + 4'h1, 4'hF}, 24);
		wait_idle();
		check(dummy_clocks_q, d);
		push(K_WR_SETUP, 5'h00);
		xfer({OP_WR_SETUP, 16'hFFFF}, 24);
		wait_idle();
		check(addr_four_byte_q, 1'b0);
		check(dummy_clocks_q, DUMMY_DEF_X4);
		check(32'(exp_q.size()), 32'h0);
		complete_run();
	end
endmodule : flash_guard_tb_top
